/* hw/phtmc_pkg.sv */
// Constants and types for the PHY transmit, management and control block
// Behaviour
// - RMII uses low two data bits only
// - SGMII data arrives on shared pair
// - Transmit error honoured in MII only
// - Management clock any rate up to limit
// - Management clock unrelated, crossed internally
// - Data line open drain, device drives reads
// - Interrupt pin low while enabled condition
// - Event sources stay disabled until software enables; power-on source enabled at reset
// - Flags stay set until cleared by access
// - Reading third status clears power-on flag
// - Test register bit makes interrupt active-high
// - Reset held low 1 us, full reset
// - Reset returns registers to defaults
// - Straps resampled when the reset count ends, 10 pclk cycles after reset release
package phtmc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_HZ = 10_000_000;
  localparam int unsigned PCLK_NS = 1_000_000_000 / PCLK_HZ;
  localparam int unsigned RESET_MIN_NS = 1000;
  localparam int unsigned RESET_CYC = (RESET_MIN_NS + PCLK_NS - 1) / PCLK_NS;
  localparam logic [3:0] RESET_LAST = 4'(RESET_CYC - 1);

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_INT_TEST = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h12;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h13;
  localparam logic [5:0] IDX_MODE = 6'h14;
  localparam logic [5:0] IDX_TX_COUNT = 6'h15;
  localparam logic [5:0] IDX_STAT3 = 6'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TEST_POL_BIT = 0;
  localparam int unsigned STAT3_POR_FLAG_BIT = 0;
  localparam int unsigned STAT3_POR_EN_BIT = 8;
  localparam int unsigned MODE_DONE_BIT = 4;
  localparam int unsigned NUM_EV = 3;
  localparam int unsigned EV_TX_ERR = 0;
  localparam int unsigned EV_TX_END = 1;
  localparam int unsigned EV_MGMT_WR = 2;
  localparam logic TEST_POL_RST = 1'b0;
  localparam logic POR_EN_RST = 1'b1;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------
  localparam logic [5:0] MG_PRE_LEN = 6'h20;
  localparam logic [5:0] MG_HDR_LAST = 6'h0c;
  localparam logic [5:0] MG_TA_LAST = 6'h01;
  localparam logic [5:0] MG_DATA_LAST = 6'h0f;
  localparam logic [1:0] MG_OP_READ = 2'h2;
  localparam logic [1:0] MG_OP_WRITE = 2'h1;
  localparam logic [4:0] MG_PHY_ADDR = 5'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PHTMC_MII = 2'h0,
    PHTMC_RMII = 2'h1,
    PHTMC_RGMII = 2'h2,
    PHTMC_SGMII = 2'h3
  } phtmc_mode_e;

  typedef enum logic [3:0] {
    MG_PRE = 4'b0001,
    MG_HDR = 4'b0010,
    MG_TA = 4'b0100,
    MG_DATA = 4'b1000
  } phtmc_mgmt_e;

  typedef struct packed {
    logic tx_clk;
    logic mdc;
    logic mdio;
    logic [3:0] tx_data;
    logic tx_valid;
    logic tx_error;
  } phtmc_pins_s;

  typedef struct packed {
    logic int_active_high;
    logic por_flag;
    logic por_en;
    logic [2:0] ev_status;
    logic [2:0] ev_mask;
    logic [1:0] mode;
    logic reset_done;
    logic [15:0] tx_count;
  } phtmc_regs_s;

endpackage

/* hw/phtmc_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module phtmc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* hw/phtmc_top.sv */
// Transmit input capture, management slave, interrupt pin and APB registers
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module phtmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clk_in,
  input wire logic [3:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_error_in,
  input wire logic [1:0] mode_strap,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic int_out,
  output logic int_oe,
  output logic irq,
  output logic [3:0] tx_nibble,
  output logic tx_nibble_valid,
  output logic tx_symbol_error,
  output logic reset_done
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == phtmc_pkg::IDX_INT_TEST) || (idx == phtmc_pkg::IDX_IRQ_STATUS) ||
                (idx == phtmc_pkg::IDX_IRQ_MASK) || (idx == phtmc_pkg::IDX_MODE) ||
                (idx == phtmc_pkg::IDX_TX_COUNT) || (idx == phtmc_pkg::IDX_STAT3);
  endfunction

  function automatic logic [15:0] reg_read(input logic [5:0] idx, input phtmc_pkg::phtmc_regs_s r);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == phtmc_pkg::IDX_INT_TEST) begin
      v[phtmc_pkg::TEST_POL_BIT] = r.int_active_high;
    end else if (idx == phtmc_pkg::IDX_IRQ_STATUS) begin
      v[phtmc_pkg::NUM_EV-1:0] = r.ev_status;
    end else if (idx == phtmc_pkg::IDX_IRQ_MASK) begin
      v[phtmc_pkg::NUM_EV-1:0] = r.ev_mask;
    end else if (idx == phtmc_pkg::IDX_MODE) begin
      v[1:0] = r.mode;
      v[phtmc_pkg::MODE_DONE_BIT] = r.reset_done;
    end else if (idx == phtmc_pkg::IDX_TX_COUNT) begin
      v = r.tx_count;
    end else if (idx == phtmc_pkg::IDX_STAT3) begin
      v[phtmc_pkg::STAT3_POR_FLAG_BIT] = r.por_flag;
      v[phtmc_pkg::STAT3_POR_EN_BIT] = r.por_en;
    end
    reg_read = v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  phtmc_pkg::phtmc_pins_s pins_raw;
  phtmc_pkg::phtmc_pins_s pins;

  assign pins_raw.tx_clk = tx_clk_in;
  assign pins_raw.mdc = mdc;
  assign pins_raw.mdio = mdio_in;
  assign pins_raw.tx_data = tx_data_in;
  assign pins_raw.tx_valid = tx_valid_in;
  assign pins_raw.tx_error = tx_error_in;

  phtmc_sync #(
    .W($bits(phtmc_pkg::phtmc_pins_s))
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins)
  );

  logic tx_clk_d;
  logic mdc_d;
  wire tx_rise = pins.tx_clk & ~tx_clk_d;
  wire mdc_rise = pins.mdc & ~mdc_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_d <= 1'b0;
      mdc_d <= 1'b0;
    end else begin
      tx_clk_d <= pins.tx_clk;
      mdc_d <= pins.mdc;
    end
  end

  // ----------------------------------------------------------------
  // Reset process and strap capture
  // ----------------------------------------------------------------
  logic [3:0] rst_cnt;
  phtmc_pkg::phtmc_mode_e mode;
  wire por_set = ~reset_done & (rst_cnt == phtmc_pkg::RESET_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= 4'h0;
      reset_done <= 1'b0;
      mode <= phtmc_pkg::PHTMC_MII;
    end else if (!reset_done) begin
      rst_cnt <= rst_cnt + 4'h1;
      if (por_set) begin
        reset_done <= 1'b1;
        mode <= phtmc_pkg::phtmc_mode_e'(mode_strap);
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit capture
  // ----------------------------------------------------------------
  logic [3:0] asm;
  logic [1:0] asm_cnt;
  logic tx_busy;
  wire tx_take = tx_rise & reset_done;
  wire sgmii_bit = pins.tx_data[1];
  wire sgmii_ok = pins.tx_data[1] ^ pins.tx_data[0];
  wire frame_valid = pins.tx_valid | (mode == phtmc_pkg::PHTMC_SGMII);
  wire ev_tx_err = tx_take & (mode == phtmc_pkg::PHTMC_MII) & pins.tx_valid & pins.tx_error;
  wire ev_tx_end = tx_take & tx_busy & ~frame_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
    end else if (tx_take) begin
      tx_busy <= frame_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_nibble <= 4'h0;
      tx_nibble_valid <= 1'b0;
      tx_symbol_error <= 1'b0;
      asm <= 4'h0;
      asm_cnt <= 2'h0;
    end else begin
      tx_nibble_valid <= 1'b0;
      if (tx_take) begin
        case (mode)
          phtmc_pkg::PHTMC_MII, phtmc_pkg::PHTMC_RGMII: begin
            tx_nibble <= pins.tx_data;
            tx_nibble_valid <= pins.tx_valid;
            tx_symbol_error <= ev_tx_err;
          end
          phtmc_pkg::PHTMC_RMII: begin
            tx_symbol_error <= 1'b0;
            if (!pins.tx_valid) begin
              asm_cnt <= 2'h0;
            end else if (asm_cnt == 2'h0) begin
              asm[1:0] <= pins.tx_data[1:0];
              asm_cnt <= 2'h1;
            end else begin
              tx_nibble <= {pins.tx_data[1:0], asm[1:0]};
              tx_nibble_valid <= 1'b1;
              asm_cnt <= 2'h0;
            end
          end
          default: begin
            tx_symbol_error <= 1'b0;
            if (sgmii_ok) begin
              asm <= {sgmii_bit, asm[3:1]};
              asm_cnt <= asm_cnt + 2'h1;
              if (asm_cnt == 2'h3) begin
                tx_nibble <= {sgmii_bit, asm[3:1]};
                tx_nibble_valid <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Management frame slave
  // ----------------------------------------------------------------
  phtmc_pkg::phtmc_mgmt_e mg_st;
  logic [5:0] mg_cnt;
  logic [15:0] mg_sh;
  logic mg_read;
  logic [4:0] mg_reg;
  phtmc_pkg::phtmc_regs_s regs;
  wire mdio_b = pins.mdio;
  wire [12:0] hdr_full = {mg_sh[11:0], mdio_b};
  wire [1:0] hdr_op = hdr_full[11:10];
  wire hdr_read = hdr_op == phtmc_pkg::MG_OP_READ;
  wire hdr_ok = hdr_full[12] & (hdr_full[9:5] == phtmc_pkg::MG_PHY_ADDR) &
                (hdr_read | (hdr_op == phtmc_pkg::MG_OP_WRITE));
  wire hdr_end = mdc_rise & (mg_st == phtmc_pkg::MG_HDR) & (mg_cnt == phtmc_pkg::MG_HDR_LAST);
  wire mg_rd_hit = hdr_end & hdr_ok & hdr_read;
  wire mg_wr = mdc_rise & (mg_st == phtmc_pkg::MG_DATA) & ~mg_read & (mg_cnt == phtmc_pkg::MG_DATA_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mg_st <= phtmc_pkg::MG_PRE;
      mg_cnt <= 6'h00;
      mg_sh <= 16'h0000;
      mg_read <= 1'b0;
      mg_reg <= 5'h00;
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else if (mdc_rise) begin
      case (mg_st)
        phtmc_pkg::MG_PRE: begin
          mdio_oe <= 1'b0;
          if (mdio_b) begin
            mg_cnt <= (mg_cnt == phtmc_pkg::MG_PRE_LEN) ? mg_cnt : mg_cnt + 6'h01;
          end else if (mg_cnt == phtmc_pkg::MG_PRE_LEN) begin
            mg_st <= phtmc_pkg::MG_HDR;
            mg_cnt <= 6'h00;
          end else begin
            mg_cnt <= 6'h00;
          end
        end
        phtmc_pkg::MG_HDR: begin
          mg_sh <= {mg_sh[14:0], mdio_b};
          mg_cnt <= mg_cnt + 6'h01;
          if (hdr_end) begin
            mg_cnt <= 6'h00;
            mg_st <= hdr_ok ? phtmc_pkg::MG_TA : phtmc_pkg::MG_PRE;
            mg_read <= hdr_read;
            mg_reg <= hdr_full[4:0];
            if (hdr_read) begin
              mg_sh <= reg_read({1'b0, hdr_full[4:0]}, regs);
            end
          end
        end
        phtmc_pkg::MG_TA: begin
          mg_cnt <= mg_cnt + 6'h01;
          if (mg_cnt != phtmc_pkg::MG_TA_LAST) begin
            mdio_oe <= mg_read;
          end else begin
            mg_st <= phtmc_pkg::MG_DATA;
            mg_cnt <= 6'h00;
            if (mg_read) begin
              mdio_oe <= ~mg_sh[15];
              mg_sh <= {mg_sh[14:0], 1'b0};
            end
          end
        end
        default: begin
          mg_cnt <= mg_cnt + 6'h01;
          if (mg_read) begin
            mdio_oe <= ~mg_sh[15];
            mg_sh <= {mg_sh[14:0], 1'b0};
          end else begin
            mg_sh <= {mg_sh[14:0], mdio_b};
          end
          if (mg_cnt == phtmc_pkg::MG_DATA_LAST) begin
            mdio_oe <= 1'b0;
            mg_st <= phtmc_pkg::MG_PRE;
            mg_cnt <= 6'h00;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire [5:0] apb_idx = paddr[7:2];
  wire apb_hit = (paddr[1:0] == 2'h0) & is_mapped(apb_idx);
  wire apb_acc = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire apb_wr = apb_done & pwrite & apb_hit;
  wire apb_rd = apb_done & ~pwrite & apb_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~apb_hit;
      prdata <= (apb_acc & ~pwrite & apb_hit) ? {16'h0000, reg_read(apb_idx, regs)} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic int_active_high;
  logic por_flag;
  logic por_en;
  logic [2:0] ev_status;
  logic [2:0] ev_mask;
  logic [15:0] tx_count;

  assign regs.int_active_high = int_active_high;
  assign regs.por_flag = por_flag;
  assign regs.por_en = por_en;
  assign regs.ev_status = ev_status;
  assign regs.ev_mask = ev_mask;
  assign regs.mode = mode;
  assign regs.reset_done = reset_done;
  assign regs.tx_count = tx_count;

  wire wr_en = apb_wr | mg_wr;
  wire [5:0] wr_idx = apb_wr ? apb_idx : {1'b0, mg_reg};
  wire [15:0] wr_data = apb_wr ? pwdata[15:0] : {mg_sh[14:0], mdio_b};
  wire [2:0] ev_set = {mg_wr, ev_tx_end, ev_tx_err};
  wire [2:0] ev_clr = (wr_en & (wr_idx == phtmc_pkg::IDX_IRQ_STATUS)) ? wr_data[2:0] : 3'h0;
  wire [2:0] next_ev_status = ev_set | (ev_status & ~ev_clr);
  wire stat3_rd = (apb_rd & (apb_idx == phtmc_pkg::IDX_STAT3)) |
                  (mg_rd_hit & ({1'b0, hdr_full[4:0]} == phtmc_pkg::IDX_STAT3));
  wire next_por_flag = por_set | (por_flag & ~stat3_rd);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_active_high <= phtmc_pkg::TEST_POL_RST;
      por_en <= phtmc_pkg::POR_EN_RST;
      por_flag <= 1'b0;
      ev_status <= 3'h0;
      ev_mask <= phtmc_pkg::IRQ_MASK_RST;
      tx_count <= 16'h0000;
    end else begin
      if (wr_en && (wr_idx == phtmc_pkg::IDX_INT_TEST)) begin
        int_active_high <= wr_data[phtmc_pkg::TEST_POL_BIT];
      end
      if (wr_en && (wr_idx == phtmc_pkg::IDX_STAT3)) begin
        por_en <= wr_data[phtmc_pkg::STAT3_POR_EN_BIT];
      end
      if (wr_en && (wr_idx == phtmc_pkg::IDX_IRQ_MASK)) begin
        ev_mask <= wr_data[2:0];
      end
      por_flag <= next_por_flag;
      ev_status <= next_ev_status;
      if (ev_tx_end) begin
        tx_count <= tx_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  wire irq_next = (|(ev_status & ev_mask)) | (por_flag & por_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      int_oe <= 1'b0;
      int_out <= 1'b0;
    end else begin
      irq <= irq_next;
      int_oe <= int_active_high ? ~irq_next : irq_next;
    end
  end

endmodule
`default_nettype wire

/* tb/phtmc_mac_model.sv */
// MAC and management station model driving the transmit and management pins
`timescale 1ns/10ps
`default_nettype none
module phtmc_mac_model (
  output logic tx_clk,
  output logic [3:0] tx_data,
  output logic tx_valid,
  output logic tx_error,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_oe
);
  logic st_oe = 1'b0;
  logic st_val = 1'b1;
  initial begin
    tx_clk = 1'b0;
    tx_data = 4'h0;
    tx_valid = 1'b0;
    tx_error = 1'b0;
    mdc = 1'b0;
  end
  // Open-drain wire with pull-up
  assign mdio_in = !(st_oe && !st_val) && !mdio_oe;
  // One link clock period, data set up before the rise, clock idle low
  // Starts half a system cycle after the caller's edge, so no pin moves on a sampling edge
  task automatic nib(input logic [3:0] d, input logic v, input logic e);
    #50;
    tx_data = d;
    tx_valid = v;
    tx_error = e;
    #400 tx_clk = 1'b1;
    #400 tx_clk = 1'b0;
    tx_data = ~d;
  endtask
  // Station changes on the fall, samples just before the rise
  task automatic mclk(input logic b, input logic oe, output logic s);
    st_oe = oe;
    st_val = b;
    #500 s = mdio_in;
    mdc = 1'b1;
    #500 mdc = 1'b0;
  endtask
  task automatic mframe(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hffff_ffff, 2'b01, op, phtmc_pkg::MG_PHY_ADDR, ra, 2'b10, wd};
    rd = 16'h0000;
    #50;
    for (int i = 63; i >= 0; i--) begin
      mclk(f[i], (op == phtmc_pkg::MG_OP_WRITE) || (i > 17), s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    st_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/phtmc_props.sv */
// Port-level assertions for the transmit, management and interrupt block
`timescale 1ns/10ps
`default_nettype none
module phtmc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic irq,
  input wire logic tx_nibble_valid,
  input wire logic reset_done
);
  // ----
  // Checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mdio_od;
    mdio_oe |-> mdio_out == 1'b0;
  endproperty
  a_mdio_od: assert property (p_mdio_od) else $error("data line driven high");
  property p_int_od;
    int_oe |-> int_out == 1'b0;
  endproperty
  a_int_od: assert property (p_int_od) else $error("interrupt pin driven high");
  property p_int_follow;
    $changed(irq) |-> $changed(int_oe);
  endproperty
  a_int_follow: assert property (p_int_follow) else $error("pin did not follow irq");
  property p_por_irq;
    $rose(reset_done) |=> irq && int_oe;
  endproperty
  a_por_irq: assert property (p_por_irq) else $error("no power-on interrupt");
  property p_irq_hold;
    irq && !psel && !$past(psel) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without access");
  property p_ready_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready too long");
  property p_slverr;
    pready && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("misaligned not refused");
  property p_tx_gate;
    !reset_done |-> !tx_nibble_valid;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("capture before reset done");
  property p_tx_pulse;
    tx_nibble_valid |=> !tx_nibble_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("nibble valid too long");
endmodule
bind phtmc_top phtmc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .int_out(int_out), .int_oe(int_oe), .irq(irq), .tx_nibble_valid(tx_nibble_valid), .reset_done(reset_done));
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the transmit, management and interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [7:0] A_TEST = {phtmc_pkg::IDX_INT_TEST, 2'b00};
  localparam logic [7:0] A_STAT = {phtmc_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MASK = {phtmc_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_MODE = {phtmc_pkg::IDX_MODE, 2'b00};
  localparam logic [7:0] A_CNT = {phtmc_pkg::IDX_TX_COUNT, 2'b00};
  localparam logic [7:0] A_ST3 = {phtmc_pkg::IDX_STAT3, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] mode_strap = 2'h0;
  logic [31:0] prdata, rd;
  logic [15:0] mrd;
  logic [3:0] tx_data, nib;
  logic pready, pslverr, tx_clk, tx_valid, tx_error, mdc, mdio_in, mdio_out, mdio_oe, err;
  logic int_out, int_oe, irq, nib_valid, sym_err, reset_done;
  logic last_err = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int nv_count = 0;
  always #50 pclk = ~pclk;
  phtmc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_clk_in(tx_clk), .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_error_in(tx_error),
    .mode_strap(mode_strap), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .int_out(int_out), .int_oe(int_oe), .irq(irq), .tx_nibble(nib), .tx_nibble_valid(nib_valid),
    .tx_symbol_error(sym_err), .reset_done(reset_done));
  phtmc_mac_model mac (.tx_clk(tx_clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_error(tx_error),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_oe(mdio_oe));
  // ----
  // Tasks
  // ----
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic txn(input logic [3:0] d, input logic v, input logic e);
    mac.nib(d, v, e);
    repeat (3) @(posedge pclk);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_strap <= m;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (nib_valid === 1'b1) begin
      nv_count <= nv_count + 1;
      last_err <= sym_err;
    end
    if (cycles == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    do_reset(2'h0);
    chk({30'h0, irq, int_oe}, 32'h3);
    rdx(A_TEST, 32'h0);
    rdx(A_MASK, 32'h0);
    rdx(A_ST3, 32'h0000_0101);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdx(A_ST3, 32'h0000_0100);
    apb(1'b1, A_TEST, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({30'h0, irq, int_oe}, 32'h1);
    apb(1'b1, A_TEST, 32'h0000_0000);
    rdx(8'h45, 32'h0);
    chk({31'h0, err}, 32'h1);
    rdx(8'h70, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test defaults done");
    txn(4'ha, 1'b1, 1'b0);
    chk({28'h0, nib}, 32'ha);
    txn(4'h5, 1'b1, 1'b1);
    chk({27'h0, last_err, nib}, 32'h15);
    txn(4'h0, 1'b0, 1'b0);
    chk(32'(nv_count), 32'h2);
    chk({31'h0, irq}, 32'h0);
    rdx(A_STAT, 32'h3);
    rdx(A_CNT, 32'h1);
    apb(1'b1, A_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_STAT, 32'h1);
    rdx(A_STAT, 32'h2);
    chk({30'h0, irq, int_oe}, 32'h3);
    apb(1'b1, A_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test mii done");
    mac.mframe(phtmc_pkg::MG_OP_WRITE, 5'h11, 16'h0001, mrd);
    rdx(A_TEST, 32'h1);
    rdx(A_STAT, 32'h4);
    mac.mframe(phtmc_pkg::MG_OP_READ, 5'h13, 16'h0000, mrd);
    chk({16'h0, mrd}, 32'h3);
    $display("test mdio done");
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      rdx(A_MODE, {27'h0, 1'b1, 2'h0, m[1:0]});
      rdx(A_TEST, 32'h0);
      rdx(A_MASK, 32'h0);
    end
    apb(1'b1, A_ST3, 32'h0000_0000);
    mac.mframe(phtmc_pkg::MG_OP_READ, 5'h18, 16'h0000, mrd);
    chk({16'h0, mrd}, 32'h1);
    rdx(A_ST3, 32'h0);
    txn(4'h2, 1'b0, 1'b0);
    txn(4'h1, 1'b0, 1'b0);
    txn(4'h2, 1'b0, 1'b0);
    txn(4'h2, 1'b0, 1'b0);
    chk({28'h0, nib}, 32'hd);
    do_reset(2'h1);
    txn(4'he, 1'b1, 1'b1);
    txn(4'h5, 1'b1, 1'b1);
    chk({27'h0, last_err, nib}, 32'h6);
    $display("test modes done");
    complete_run;
  end
endmodule
`default_nettype wire
